// ### bench/hiur_link_asserts.sv
// checker for the link lanes between host controller and device
// assumes tb instantiates it beside the link interface
`timescale 1ns/10ps
module hiur_link_asserts (
	input wire logic       clk_sys,   // system clock
	input wire logic       resetn,    // async reset, low
	input wire logic       hostValid, // host byte present
	input wire logic [7:0] hostByte,  // host byte
	input wire logic       devValid,  // device byte present
	input wire logic [7:0] devByte,   // device byte
	input wire logic       vkPin      // toggle pin
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic prevHdr;
	//////////////////////////////////////////
	// remember a header, since $past of an expression is avoided
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			prevHdr <= 1'b0;
		else
			prevHdr <= devValid && devByte == 8'hff;
	end
	AST_LOCK_PAIR: assert property (devValid && devByte == 8'hff |=> devValid)
		else $error("lock header without status byte");
	AST_STAT_BITS: assert property (prevHdr && devValid |-> devByte[7:3] == 5'h00)
		else $error("status byte has bits above scroll");
	AST_LONE_HDR: assert property (devValid && !prevHdr |-> devByte == 8'hff)
		else $error("device byte not led by a header");
	AST_STAT_END: assert property (prevHdr |=> !devValid || devByte == 8'hff)
		else $error("extra byte after status");
	AST_HDR_SPAN: assert property ($rose(devValid) |-> devByte == 8'hff ##1 devValid)
		else $error("lock answer not two bytes");
	AST_STAT_NOT_HDR: assert property (prevHdr |-> devValid && devByte != 8'hff)
		else $error("status byte missing or equal to header");
	CV_RAW: cover property (hostValid && hostByte == 8'hfd);
	CV_PIN: cover property ($rose(vkPin));
endmodule : hiur_link_asserts

// ### bench/tb.sv
// self-checking bench: host controller and device joined by the link
// assumes a short toggle hold so the run stays brief
`timescale 1ns/10ps
module tb;
	localparam int HOLD = 20;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wrData = 32'h0;
	logic        wrEn = 1'b0;
	logic        rdEn = 1'b0;
	logic        ce = 1'b1;
	logic        remapSet = 1'b0;
	logic        remapGet = 1'b0;
	logic [15:0] remapWrData = 16'h0;
	logic        toggleEn = 1'b0;
	logic        lockReport = 1'b0;
	logic [2:0]  lockState = 3'h0;
	logic [31:0] rdData, d, seed;
	logic [15:0] remapRdData, consumerKeys, remapCopy;
	logic        irq, repValid, repFirst, repLast, keyValid, disconnect, vkToggle;
	logic [7:0]  repByte, keyByte;
	logic [9:0]  expQ[$], gotQ[$]; // first, last, byte
	logic [7:0]  expK[$], gotK[$];
	int          mismatches, n_compared, nDisc, nToggle;
	hiur_link_if hiur_link_if_inst ();
	hiur_host hiur_host_inst (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
		.link(hiur_link_if_inst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
		.rdEn(rdEn), .rdData(rdData), .irq(irq));
	hiur_device #(.HOLD_CYC(HOLD)) hiur_device_inst (.clk_sys(clk_sys), .resetn(resetn),
		.ce(ce), .link(hiur_link_if_inst), .remapSet(remapSet),
		.remapWrData(remapWrData), .remapGet(remapGet), .remapRdData(remapRdData),
		.toggleEn(toggleEn), .lockReport(lockReport), .lockState(lockState),
		.repValid(repValid), .repByte(repByte), .repFirst(repFirst), .repLast(repLast),
		.keyValid(keyValid), .keyByte(keyByte), .consumerKeys(consumerKeys),
		.disconnect(disconnect), .vkToggle(vkToggle));
	hiur_link_asserts hiur_link_asserts_inst (.clk_sys(clk_sys), .resetn(resetn),
		.hostValid(hiur_link_if_inst.hostValid), .hostByte(hiur_link_if_inst.hostByte),
		.devValid(hiur_link_if_inst.devValid), .devByte(hiur_link_if_inst.devByte),
		.vkPin(hiur_link_if_inst.vkPin));
	//////////////////////////////////////////
	// 200 mhz clock
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	// collect what the device hands on
	always @(posedge clk_sys) begin
		if (repValid === 1'b1)
			gotQ.push_back({repFirst, repLast, repByte});
		if (keyValid === 1'b1)
			gotK.push_back(keyByte);
		if (disconnect === 1'b1)
			nDisc++;
		if (vkToggle === 1'b1)
			nToggle++;
	end
	function logic [31:0] lfsr(input logic [31:0] x);
		return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
	endfunction : lfsr
	// expected byte after the substitution
	function logic [7:0] mapB(input logic [7:0] b);
		return (remapCopy != 16'h0 && b == remapCopy[15:8]) ? remapCopy[7:0] : b;
	endfunction : mapB
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		addr <= a;
		wrData <= v;
		wrEn <= 1'b1;
		@(posedge clk_sys);
		wrEn <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clk_sys);
		rdEn <= 1'b0;
		#1 d = rdData;
	endtask : rd
	// plain key byte; zero after substitution means a drop
	task key(input logic [7:0] b);
		wr(8'h00, {24'h0, b});
		if (mapB(b) != 8'h00)
			expK.push_back(mapB(b));
	endtask : key
	// raw report: start, length, descriptor, length-1 data bytes
	task rep(input logic [7:0] len, input logic [7:0] desc, input logic [15:0] lo);
		logic [7:0] b;
		wr(8'h00, 32'hfd);
		wr(8'h00, {24'h0, len});
		// first and last markers ride above the byte
		expQ.push_back({2'b10, len});
		wr(8'h00, {24'h0, desc});
		expQ.push_back({1'b0, len == 8'h01, desc});
		for (int i = 1; i < len; i++) begin
			seed = lfsr(seed);
			b = (i < 3) ? lo[8*i-8 +: 8] : seed[7:0];
			wr(8'h00, {24'h0, b});
			expQ.push_back({1'b0, i == len - 1, mapB(b)});
		end
		repeat (3) @(posedge clk_sys);
	endtask : rep
	task remapOp(input logic s, input logic [15:0] v);
		@(posedge clk_sys);
		remapSet <= s;
		remapGet <= ~s;
		remapWrData <= v;
		@(posedge clk_sys);
		remapSet <= 1'b0;
		remapGet <= 1'b0;
		#1 remapCopy = s ? v : remapCopy;
	endtask : remapOp
	task lockOp(input logic [2:0] s);
		@(posedge clk_sys);
		lockReport <= 1'b1;
		lockState <= s;
		@(posedge clk_sys);
		lockReport <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rd(8'h04);
		chk("lock", d, {29'h0, s});
	endtask : lockOp
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	//////////////////////////////////////////
	// hang guard, well beyond the expected few hundred cycles
	initial begin
		#100000;
		mismatches++;
		stop_test;
	end
	// main sequence
	initial begin
		{mismatches, n_compared, nDisc, nToggle} = '0;
		seed = 32'h8f82;
		remapCopy = 16'h0;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		remapOp(1'b0, 16'h0);
		chk("remap", remapRdData, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			rep(8'h03, 8'h03, 16'h1 << i);
			key(8'h41);
			chk("consumer", consumerKeys, 16'h1 << i);
		end
		rep(8'h03, 8'h03, 16'h0);
		chk("release", consumerKeys, 16'h0);
		seed = lfsr(seed);
		rep(8'h09, 8'h01, seed[15:0]);
		rep(8'h05, 8'h02, seed[31:16]);
		rep(8'h05, 8'h02, 16'h2000);
		rep(8'h09, 8'h01, 16'h0400);
		// empty report ends on its length byte, next zero is a drop
		wr(8'h00, 32'hfd);
		wr(8'h00, 32'h00);
		expQ.push_back(10'h300);
		key(8'h00);
		remapOp(1'b1, 16'h7e7f);
		remapOp(1'b0, 16'h0);
		chk("remap get", remapRdData, 16'h7e7f);
		key(8'h7e);
		remapOp(1'b1, 16'h5a00);
		key(8'h5a);
		key(8'h41);
		remapOp(1'b1, 16'h0);
		// frozen host drops a write; a held byte is taken only once
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(8'h00, 32'h41);
		ce <= 1'b1;
		key(8'h42);
		ce <= 1'b0;
		@(posedge clk_sys);
		ce <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("drops", nDisc, 2);
		wr(8'h0c, 32'h1);
		rd(8'h0c);
		chk("irq enable", d, 32'h1);
		for (int i = 0; i < 3; i++)
			lockOp(3'h1 << i);
		lockOp(3'h7);
		rd(8'h08);
		chk("status", d, 32'h1);
		chk("irq", irq, 1'b1);
		wr(8'h10, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("irq clr", irq, 1'b0);
		rd(8'h20);
		chk("unmapped", d, 32'h0);
		wr(8'h14, 32'h1);
		repeat (2 * HOLD) @(posedge clk_sys);
		wr(8'h14, 32'h0);
		toggleEn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("toggle off", nToggle, 0);
		wr(8'h14, 32'h1);
		repeat (HOLD - 8) @(posedge clk_sys);
		wr(8'h14, 32'h0);
		repeat (4) @(posedge clk_sys);
		chk("short hold", nToggle, 0);
		wr(8'h14, 32'h1);
		repeat (2 * HOLD) @(posedge clk_sys);
		chk("long hold", nToggle, 1);
		chk("rep count", gotQ.size(), expQ.size());
		foreach (expQ[i])
			chk("rep byte", gotQ[i], expQ[i]);
		chk("key count", gotK.size(), expK.size());
		foreach (expK[i])
			chk("key byte", gotK[i], expK[i]);
		stop_test;
	end
endmodule : tb

// ### hw/hiur_consts.svh
// constants for the hid uart report interpreter: codes, lengths, offsets, times
// assumes one 200 MHz system clock shared by both ends
// Behaviour
// R1: 0xfd starts raw report, forwarded without start
// R2: mouse report: start, length 5, descriptor 2
// R3: combo mode: each complete report forwarded alone
// R4: consumer report: start, 3, 3, low, high
// R5: each bitmap bit is one media key
// R6: all-zero consumer bitmap releases held keys
// R7: lock report goes out as 0xff, status
// R8: status bits: num 1, caps 2, scroll 4
// R9: toggle needs rising edge held 200 ms
// R10: toggle pin ignored unless toggle enabled
// R11: nonzero remap swaps upper byte for lower
// R12: remap written by set, read by get
// R13: remap setting resets to zero, disabled
// R14: key byte 0x00 drops the connection
// R15: remap to 00 makes a disconnect key
// R16: parser idles after length bytes, then resyncs
`ifndef HIUR_CONSTS_SVH
`define HIUR_CONSTS_SVH

// stream codes
`define HIUR_RAW_START   8'hfd
`define HIUR_LOCK_START  8'hff
`define HIUR_DISC_KEY    8'h00
`define HIUR_DESC_MOUSE  8'h02
`define HIUR_LEN_MOUSE   8'h05
`define HIUR_DESC_CONS   8'h03
`define HIUR_LEN_CONS    8'h03

// lock status bit positions
`define HIUR_LOCK_NUM    0
`define HIUR_LOCK_CAPS   1
`define HIUR_LOCK_SCROLL 2

// reset values
`define HIUR_REMAP_RESET 16'h0000

// toggle hold time
`define HIUR_VK_HOLD_MS  200
`define HIUR_CLK_KHZ     200000
`define HIUR_VK_HOLD_CYC (`HIUR_VK_HOLD_MS * `HIUR_CLK_KHZ)

// host controller register offsets
`define HIUR_REG_TXDATA  8'h00
`define HIUR_REG_LOCK    8'h04
`define HIUR_REG_STATUS  8'h08
`define HIUR_REG_IRQEN   8'h0c
`define HIUR_REG_CLEAR   8'h10
`define HIUR_REG_PIN     8'h14

// host event bit positions
`define HIUR_EV_LOCK     0
`define HIUR_EV_STRAY    1

`endif

// ### hw/hiur_device.sv
// interpreter device end: parses host bytes, forwards raw reports,
// keeps consumer keys, sends lock status, times the toggle pin
// assumes host bytes arrive on clk_sys, toggle pin is asynchronous
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "hiur_consts.svh"
module hiur_device #(
	parameter int HOLD_CYC = `HIUR_VK_HOLD_CYC // toggle hold in cycles
) (
	input  wire logic        clk_sys,      // system clock
	input  wire logic        resetn,       // async reset, low
	input  wire logic        ce,           // clock enable
	hiur_link_if.dev         link,         // link to host
	input  wire logic        remapSet,     // set command strobe
	input  wire logic [15:0] remapWrData,  // new remap word
	input  wire logic        remapGet,     // get command strobe
	output logic [15:0]      remapRdData,  // remap word, next cycle
	input  wire logic        toggleEn,     // hid flag toggle enable
	input  wire logic        lockReport,   // remote lock state pulse
	input  wire logic [2:0]  lockState,    // scroll, caps, num
	output logic             repValid,     // forwarded report byte
	output logic [7:0]       repByte,      // report byte value
	output logic             repFirst,     // length byte marker
	output logic             repLast,      // final byte marker
	output logic             keyValid,     // plain key byte
	output logic [7:0]       keyByte,      // plain key value
	output logic [15:0]      consumerKeys, // held consumer keys
	output logic             disconnect,   // drop connection pulse
	output logic             vkToggle      // keyboard toggle pulse
);
	import hiur_pkg::*;

	localparam logic [25:0] HOLD_LAST = 26'(HOLD_CYC - 1);

	hiur_dev_t s_r, s_nxt;

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [7:0] b;
		logic       isCons;
		b = 8'h00;
		isCons = 1'b0;
		s_nxt = s_r;

		// pulse outputs default low
		s_nxt.repValid   = 1'b0;
		s_nxt.repFirst   = 1'b0;
		s_nxt.repLast    = 1'b0;
		s_nxt.keyValid   = 1'b0;
		s_nxt.disconnect = 1'b0;
		s_nxt.vkToggle   = 1'b0;
		s_nxt.devValid   = 1'b0;

		// remap before anything looks at the byte
		if (s_r.remap != `HIUR_REMAP_RESET && link.hostByte == s_r.remap[15:8]) begin
			b = s_r.remap[7:0]; // see R11
		end else begin
			b = link.hostByte;
		end

		// consumer report is recognised by its length and descriptor
		isCons = (s_r.desc == `HIUR_DESC_CONS) && (s_r.repLen == `HIUR_LEN_CONS); // see R4

		////////////////////////////////////////////////////////////////
		// report parser
		if (link.hostValid) begin
			case (s_r.rxSt)
				RX_IDLE: begin
					if (b == `HIUR_RAW_START) begin
						// start byte is stripped, never forwarded
						s_nxt.rxSt = RX_LEN; // see R1
					end else if (b == `HIUR_DISC_KEY) begin
						// checked after remap, so a mapped key disconnects
						s_nxt.disconnect = 1'b1; // see R14 see R15
					end else begin
						// other keys handed on for translation elsewhere
						s_nxt.keyValid = 1'b1;
						s_nxt.keyByte  = b;
					end
				end
				RX_LEN: begin
					s_nxt.remain   = b;
					s_nxt.repLen   = b;
					s_nxt.repValid = 1'b1;
					s_nxt.repByte  = b;
					s_nxt.repFirst = 1'b1;
					if (b == 8'h00) begin
						// empty report ends on its length byte
						s_nxt.repLast = 1'b1;
						s_nxt.rxSt    = RX_IDLE; // see R16
					end else begin
						s_nxt.rxSt = RX_DESC;
					end
				end
				RX_DESC, RX_BODY: begin
					// every body byte goes out after the remap, any descriptor
					s_nxt.repValid = 1'b1; // see R1 see R2 see R3
					s_nxt.repByte  = b;
					s_nxt.remain   = s_r.remain - 8'h01;
					if (s_r.rxSt == RX_DESC) begin
						s_nxt.desc = b;
					end
					// consumer bitmap: low byte staged, applied with high
					if (s_r.rxSt == RX_BODY && isCons) begin
						if (s_r.remain == 8'h02) begin
							s_nxt.consLow = b;
						end
						if (s_r.remain == 8'h01) begin
							// zero bitmap releases, others stay held
							s_nxt.consumer = {b, s_r.consLow}; // see R5 see R6
						end
					end
					if (s_r.remain == 8'h01) begin
						// length counted out, look for next start byte
						s_nxt.repLast = 1'b1;
						s_nxt.rxSt    = RX_IDLE; // see R16
					end else begin
						s_nxt.rxSt = RX_BODY;
					end
				end
				default: begin
					s_nxt.rxSt = RX_IDLE;
				end
			endcase
		end

		////////////////////////////////////////////////////////////////
		// remap set and get commands
		if (remapSet) begin
			s_nxt.remap = remapWrData; // see R12
		end
		if (remapGet) begin
			s_nxt.remapRd = s_r.remap; // see R12
		end

		////////////////////////////////////////////////////////////////
		// toggle pin: two flops, then rising edge held for the hold time
		s_nxt.syncA = link.vkPin;
		s_nxt.syncB = s_r.syncA;
		if (!toggleEn || !s_r.syncB) begin
			// low level arms; disabled pin never arms
			s_nxt.armed   = toggleEn && !s_r.syncB; // see R10
			s_nxt.holdCnt = 26'h0;
		end else if (s_r.armed) begin
			if (s_r.holdCnt == HOLD_LAST) begin
				// one toggle per rising edge, needs a low to rearm
				s_nxt.vkToggle = 1'b1; // see R9
				s_nxt.armed    = 1'b0;
			end else begin
				s_nxt.holdCnt = s_r.holdCnt + 26'h1;
			end
		end

		////////////////////////////////////////////////////////////////
		// lock status sender: 0xff then the status byte
		case (s_r.txSt)
			TX_IDLE: begin
				if (s_r.lockPend) begin
					s_nxt.devValid = 1'b1;
					s_nxt.devByte  = `HIUR_LOCK_START; // see R7
					s_nxt.lockPend = 1'b0;
					s_nxt.txSt     = TX_STAT;
				end
			end
			TX_STAT: begin
				s_nxt.devValid = 1'b1;
				s_nxt.devByte  = {5'h00, s_r.lockBits}; // see R7 see R8
				s_nxt.txSt     = TX_IDLE;
			end
			default: begin
				s_nxt.txSt = TX_IDLE;
			end
		endcase

		// a new report wins over the pending clear above
		if (lockReport) begin
			s_nxt.lockBits[`HIUR_LOCK_NUM]    = lockState[0]; // see R8
			s_nxt.lockBits[`HIUR_LOCK_CAPS]   = lockState[1];
			s_nxt.lockBits[`HIUR_LOCK_SCROLL] = lockState[2];
			s_nxt.lockPend = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register; remap resets to zero, so remapping starts disabled
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_r       <= '0;
			s_r.remap <= `HIUR_REMAP_RESET; // see R13
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state flops
	assign link.devValid = s_r.devValid;
	assign link.devByte  = s_r.devByte;
	assign remapRdData   = s_r.remapRd;
	assign repValid      = s_r.repValid;
	assign repByte       = s_r.repByte;
	assign repFirst      = s_r.repFirst;
	assign repLast       = s_r.repLast;
	assign keyValid      = s_r.keyValid;
	assign keyByte       = s_r.keyByte;
	assign consumerKeys  = s_r.consumer;
	assign disconnect    = s_r.disconnect;
	assign vkToggle      = s_r.vkToggle;

endmodule : hiur_device

// ### hw/hiur_host.sv
// host controller end: register port in, byte link out
// assumes the device answers lock reports as two back to back bytes
`timescale 1ns/10ps
`include "hiur_consts.svh"
module hiur_host (
	input  wire logic        clk_sys,   // system clock
	input  wire logic        resetn,    // async reset, low
	input  wire logic        ce,        // clock enable
	hiur_link_if.host        link,      // link to device
	input  wire logic [7:0]  addr,      // register byte address
	input  wire logic [31:0] wrData,    // write data
	input  wire logic        wrEn,      // write strobe
	input  wire logic        rdEn,      // read strobe
	output logic [31:0]      rdData,    // read data, next cycle
	output logic             irq        // level interrupt
);
	import hiur_pkg::*;

	hiur_host_t s_r, s_nxt;

	////////////////////////////////////////////////////////////////////////
	// register decode, link driving and event capture
	always_comb begin
		logic [1:0] ev;
		ev = 2'h0;
		s_nxt = s_r;
		s_nxt.hostValid = 1'b0;
		// writes: tx byte is a single cycle on the link, no queue
		if (wrEn) begin
			case (addr)
				`HIUR_REG_TXDATA: begin
					s_nxt.hostValid = 1'b1;
					s_nxt.hostByte  = wrData[7:0];
				end
				`HIUR_REG_IRQEN: s_nxt.irqEn = wrData[1:0];
				`HIUR_REG_CLEAR: s_nxt.status = s_r.status & ~wrData[1:0];
				`HIUR_REG_PIN:   s_nxt.vkPin = wrData[0];
				default: ;
			endcase
		end
		// reads: unmapped offsets answer zero
		if (rdEn) begin
			case (addr)
				`HIUR_REG_LOCK:   s_nxt.rdData = {29'h0, s_r.lockStat};
				`HIUR_REG_STATUS: s_nxt.rdData = {30'h0, s_r.status};
				`HIUR_REG_IRQEN:  s_nxt.rdData = {30'h0, s_r.irqEn};
				`HIUR_REG_PIN:    s_nxt.rdData = {31'h0, s_r.vkPin};
				default:          s_nxt.rdData = 32'h0;
			endcase
		end
		// lock report: start byte then one status byte
		if (link.devValid) begin
			if (s_r.gotStart) begin
				s_nxt.gotStart = 1'b0;
				s_nxt.lockStat = link.devByte[2:0]; // see R7 see R8
				ev[`HIUR_EV_LOCK] = 1'b1;
			end else if (link.devByte == `HIUR_LOCK_START) begin
				s_nxt.gotStart = 1'b1;
			end else begin
				ev[`HIUR_EV_STRAY] = 1'b1;
			end
		end
		// set wins over a clear in the same cycle
		s_nxt.status = s_nxt.status | ev;
		s_nxt.irq = |(s_nxt.status & s_nxt.irqEn);
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign link.hostValid = s_r.hostValid;
	assign link.hostByte  = s_r.hostByte;
	assign link.vkPin     = s_r.vkPin;
	assign rdData         = s_r.rdData;
	assign irq            = s_r.irq;

endmodule : hiur_host

// ### hw/hiur_link_if.sv
// link between host controller and interpreter device
// assumes both ends run on the same clk_sys
`timescale 1ns/10ps
interface hiur_link_if;
	logic       hostValid; // host byte present
	logic [7:0] hostByte;  // host to device byte
	logic       devValid;  // device byte present
	logic [7:0] devByte;   // device to host byte
	logic       vkPin;     // virtual keyboard toggle pin

	modport dev  (input hostValid, hostByte, vkPin, output devValid, devByte);
	modport host (output hostValid, hostByte, vkPin, input devValid, devByte);
endinterface : hiur_link_if

// ### hw/hiur_pkg.sv
// types shared by both ends of the hid uart report interpreter
// assumes hiur_consts.svh for all numbers
package hiur_pkg;

	// report parser states
	typedef enum logic [1:0] {RX_IDLE, RX_LEN, RX_DESC, RX_BODY} hiur_rx_t;

	// lock report sender states
	typedef enum logic {TX_IDLE, TX_STAT} hiur_tx_t;

	// whole state of the device end
	typedef struct packed {
		hiur_rx_t   rxSt;
		logic [7:0] remain;
		logic [7:0] repLen;
		logic [7:0] desc;
		logic [7:0] consLow;
		logic [15:0] consumer;
		logic [15:0] remap;
		logic [15:0] remapRd;
		logic       syncA;
		logic       syncB;
		logic       armed;
		logic [25:0] holdCnt;
		logic       vkToggle;
		hiur_tx_t   txSt;
		logic [2:0] lockBits;
		logic       lockPend;
		logic       devValid;
		logic [7:0] devByte;
		logic       repValid;
		logic [7:0] repByte;
		logic       repFirst;
		logic       repLast;
		logic       keyValid;
		logic [7:0] keyByte;
		logic       disconnect;
	} hiur_dev_t;

	// whole state of the host end
	typedef struct packed {
		logic       hostValid;
		logic [7:0] hostByte;
		logic       vkPin;
		logic       gotStart;
		logic [2:0] lockStat;
		logic [1:0] status;
		logic [1:0] irqEn;
		logic [31:0] rdData;
		logic       irq;
	} hiur_host_t;

endpackage : hiur_pkg
